// file: hw/reg_field.sv
`timescale 1ns/1ns
module reg_field #(
   parameter int HI = 7,
   parameter int LO = 0,
   parameter regfield_pkg::field_access_t ACCESS = regfield_pkg::ACC_RW,
   parameter logic [HI-LO:0] RESET = '0,
   parameter bit HAS_RESET = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wr_hit,
   input wire logic rd_hit,
   input wire logic [31:0] wdata,
   input wire logic [HI-LO:0] hw_set,
   input wire logic [HI-LO:0] hw_value,
   output logic [HI-LO:0] value,
   output logic [31:0] rd_view
);

   logic [HI-LO:0] next_value;
   logic [HI-LO:0] wbits;

   // field sits in bits lo through hi of the data word, both ends included
   assign wbits = wdata[HI:LO];

   // hardware sets beat a same-cycle software clear so no event is lost
   always_comb begin
      next_value = value;
      case (ACCESS)
         regfield_pkg::ACC_RW: begin
            if (wr_hit) next_value = wbits;
         end
         regfield_pkg::ACC_RO: begin
            next_value = hw_value; // writes never reach a read-only field
         end
         regfield_pkg::ACC_RC: begin
            if (rd_hit) next_value = '0;
            next_value = next_value | hw_set;
         end
         regfield_pkg::ACC_WAC: begin
            if (wr_hit) next_value = '0;
            next_value = next_value | hw_set;
         end
         regfield_pkg::ACC_RW1C, regfield_pkg::ACC_W1C: begin
            if (wr_hit) next_value = value & ~wbits;
            next_value = next_value | hw_set;
         end
         regfield_pkg::ACC_W1S: begin
            if (wr_hit) next_value = value | wbits;
         end
         default: next_value = value;
      endcase
   end

   // an undefined-at-reset field simply skips the reset load
   always_ff @(posedge clk) begin
      if (sys_rst && HAS_RESET) value <= RESET;
      else value <= next_value;
   end

   // write-only fields show zero; other bits of the word read as zero
   always_comb begin
      rd_view = 32'h0000_0000;
      if (ACCESS != regfield_pkg::ACC_W1C) rd_view[HI:LO] = value;
   end

endmodule : reg_field

// file: hw/regfield_map.svh
`ifndef REGFIELD_MAP_SVH
`define REGFIELD_MAP_SVH

// register offsets, added to the bank base address
`define OFF_CTRL 32'h0000_0000
`define OFF_RO 32'h0000_0004
`define OFF_RC 32'h0000_0008
`define OFF_WAC 32'h0000_000C
`define OFF_RW1C 32'h0000_0010
`define OFF_W1C 32'h0000_0014
`define OFF_W1S 32'h0000_0018

// field positions, upper and lower bit index, both inclusive, or lower index and width for events
`define CTRL_HI 31
`define CTRL_LO 15
`define RO_HI 31
`define RO_LO 0
`define EVT_LO 0
`define EVT_WIDTH 8

// reset values
`define RST_CTRL 17'h0_0000
`define RST_RO 32'h0000_0000
`define RST_EVT 8'h00
`define RST_W1S 8'h00

`endif

// file: hw/regfield_pkg.sv
package regfield_pkg;

   // access behaviour of one field
   typedef enum logic [2:0] {
      ACC_RW = 3'h0,
      ACC_RO = 3'h1,
      ACC_RC = 3'h2,
      ACC_WAC = 3'h3,
      ACC_RW1C = 3'h4,
      ACC_W1C = 3'h5,
      ACC_W1S = 3'h6
   } field_access_t;

   // true when an access address lands on base plus offset
   function automatic logic offset_hit(input logic [31:0] addr, input logic [31:0] base,
                                       input logic [31:0] off);
      offset_hit = (addr == 32'(base + off));
   endfunction : offset_hit

endpackage : regfield_pkg

// file: hw/register_bank.sv
`timescale 1ns/1ns
`include "regfield_map.svh"
module register_bank #(
   parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
   parameter int EVT_W = `EVT_WIDTH
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic acc_req,
   input wire logic acc_we,
   input wire logic [31:0] acc_addr,
   input wire logic [31:0] acc_wdata,
   output logic [31:0] acc_rdata,
   output logic acc_ack,
   output logic acc_miss,
   input wire logic [31:0] hw_ro_value,
   input wire logic [EVT_W-1:0] rc_set,
   input wire logic [EVT_W-1:0] wac_set,
   input wire logic [EVT_W-1:0] rw1c_set,
   input wire logic [EVT_W-1:0] w1c_set,
   output logic [`CTRL_HI-`CTRL_LO:0] ctrl_field,
   output logic [EVT_W-1:0] rc_value,
   output logic [EVT_W-1:0] wac_value,
   output logic [EVT_W-1:0] rw1c_value,
   output logic [EVT_W-1:0] w1c_value,
   output logic [EVT_W-1:0] w1s_value
);

   localparam int EVT_HI = `EVT_LO + EVT_W - 1;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic hit_ctrl, hit_ro, hit_rc, hit_wac, hit_rw1c, hit_w1c, hit_w1s;
   logic any_hit;
   logic rd_ctrl, rd_rc, rd_ro, rd_w1c;
   logic wr_ctrl, wr_ro, wr_wac, wr_rw1c, wr_w1c, wr_w1s;
   logic [31:0] ro_value;
   logic [31:0] view_ctrl, view_ro, view_rc, view_wac, view_rw1c, view_w1c, view_w1s;

   // each request is a single completed access, so effects fire once
   always_comb begin
      hit_ctrl = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_CTRL);
      hit_ro = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_RO);
      hit_rc = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_RC);
      hit_wac = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_WAC);
      hit_rw1c = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_RW1C);
      hit_w1c = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_W1C);
      hit_w1s = acc_req && regfield_pkg::offset_hit(acc_addr, BASE_ADDR, `OFF_W1S);
      any_hit = hit_ctrl | hit_ro | hit_rc | hit_wac | hit_rw1c | hit_w1c | hit_w1s;
   end

   // split hits into read and write strobes
   assign rd_ctrl = hit_ctrl && !acc_we;
   assign rd_ro = hit_ro && !acc_we;
   assign rd_rc = hit_rc && !acc_we;
   assign rd_w1c = hit_w1c && !acc_we;
   assign wr_ctrl = hit_ctrl && acc_we;
   assign wr_ro = hit_ro && acc_we;
   assign wr_wac = hit_wac && acc_we;
   assign wr_rw1c = hit_rw1c && acc_we;
   assign wr_w1c = hit_w1c && acc_we;
   assign wr_w1s = hit_w1s && acc_we;

   ////////////////////////////////////////////////////////////////////////////
   // fields

   reg_field #(.HI(`CTRL_HI), .LO(`CTRL_LO), .ACCESS(regfield_pkg::ACC_RW), .RESET(`RST_CTRL)) u_ctrl (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_ctrl), .rd_hit(rd_ctrl), .wdata(acc_wdata),
      .hw_set('0), .hw_value('0), .value(ctrl_field), .rd_view(view_ctrl));

   // read-only field follows hardware; its write strobe arrives and is ignored
   reg_field #(.HI(`RO_HI), .LO(`RO_LO), .ACCESS(regfield_pkg::ACC_RO), .RESET(`RST_RO)) u_ro (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_ro), .rd_hit(rd_ro), .wdata(acc_wdata),
      .hw_set('0), .hw_value(hw_ro_value), .value(ro_value), .rd_view(view_ro));

   reg_field #(.HI(EVT_HI), .LO(`EVT_LO), .ACCESS(regfield_pkg::ACC_RC), .RESET(EVT_W'(`RST_EVT))) u_rc (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(1'b0), .rd_hit(rd_rc), .wdata(acc_wdata),
      .hw_set(rc_set), .hw_value('0), .value(rc_value), .rd_view(view_rc));

   reg_field #(.HI(EVT_HI), .LO(`EVT_LO), .ACCESS(regfield_pkg::ACC_WAC), .RESET(EVT_W'(`RST_EVT))) u_wac (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_wac), .rd_hit(1'b0), .wdata(acc_wdata),
      .hw_set(wac_set), .hw_value('0), .value(wac_value), .rd_view(view_wac));

   reg_field #(.HI(EVT_HI), .LO(`EVT_LO), .ACCESS(regfield_pkg::ACC_RW1C), .RESET(EVT_W'(`RST_EVT))) u_rw1c (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_rw1c), .rd_hit(1'b0), .wdata(acc_wdata),
      .hw_set(rw1c_set), .hw_value('0), .value(rw1c_value), .rd_view(view_rw1c));

   reg_field #(.HI(EVT_HI), .LO(`EVT_LO), .ACCESS(regfield_pkg::ACC_W1C), .RESET(EVT_W'(`RST_EVT))) u_w1c (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_w1c), .rd_hit(1'b0), .wdata(acc_wdata),
      .hw_set(w1c_set), .hw_value('0), .value(w1c_value), .rd_view(view_w1c));

   reg_field #(.HI(EVT_HI), .LO(`EVT_LO), .ACCESS(regfield_pkg::ACC_W1S), .RESET(EVT_W'(`RST_W1S))) u_w1s (
      .clk(clk), .sys_rst(sys_rst), .wr_hit(wr_w1s), .rd_hit(1'b0), .wdata(acc_wdata),
      .hw_set('0), .hw_value('0), .value(w1s_value), .rd_view(view_w1s));

   ////////////////////////////////////////////////////////////////////////////
   // read data and answer

   logic [31:0] next_rdata;
   logic next_ack;
   logic next_miss;

   // reserved bits come back zero since each view zero-fills them
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_ack = acc_req;
      next_miss = acc_req && !any_hit; // unmapped: zero data, miss flagged
      if (acc_we) next_rdata = 32'h0000_0000;
      else if (hit_ctrl) next_rdata = view_ctrl;
      else if (hit_ro) next_rdata = view_ro;
      else if (hit_rc) next_rdata = view_rc;
      else if (hit_wac) next_rdata = view_wac;
      else if (hit_rw1c) next_rdata = view_rw1c;
      else if (hit_w1c) next_rdata = view_w1c;
      else if (hit_w1s) next_rdata = view_w1s;
   end

   // answer lands one edge after the request, straight from flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_rdata <= 32'h0000_0000;
         acc_ack <= 1'b0;
         acc_miss <= 1'b0;
      end else begin
         acc_rdata <= next_rdata;
         acc_ack <= next_ack;
         acc_miss <= next_miss;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_ctrl_write;
      wr_ctrl;
   endsequence

   sequence s_ctrl_read;
      rd_ctrl;
   endsequence

   property p_ctrl_roundtrip;
      s_ctrl_write ##1 s_ctrl_read |=> acc_rdata[`CTRL_HI:`CTRL_LO] == $past(acc_wdata[`CTRL_HI:`CTRL_LO], 2);
   endproperty

   // read-clear field: old value out, then cleared
   a_rc_read_clears: assert property (rd_rc |=> rc_value == $past(rc_set))
      else $error("read-clear field not cleared after read");
   a_rc_read_data: assert property (rd_rc |=> acc_rdata[EVT_HI:`EVT_LO] == $past(rc_value))
      else $error("read-clear field returned wrong value");
   a_rc_holds_idle: assert property (!rd_rc |=> (rc_value & $past(rc_value)) == $past(rc_value))
      else $error("read-clear field lost bits without a read");
   a_ro_write_ignored: assert property (wr_ro |=> ro_value == $past(hw_ro_value))
      else $error("write disturbed read-only field");
   a_ctrl_stores: assert property (wr_ctrl |=> ctrl_field == $past(acc_wdata[`CTRL_HI:`CTRL_LO]))
      else $error("read-write field did not store");
   a_ctrl_roundtrip: assert property (p_ctrl_roundtrip)
      else $error("read-write field readback mismatch");
   a_ctrl_reserved_zero: assert property (rd_ctrl |=> acc_rdata[`CTRL_LO-1:0] == '0)
      else $error("reserved bits read nonzero");
   a_wac_clears: assert property (wr_wac |=> wac_value == $past(wac_set))
      else $error("write-any-clears field not cleared");
   // one-clear fields: written ones clear, hardware sets still win
   a_rw1c_clears: assert property (wr_rw1c |=> rw1c_value ==
      (($past(rw1c_value) & ~$past(acc_wdata[EVT_HI:`EVT_LO])) | $past(rw1c_set)))
      else $error("one-clear field wrong after write");
   a_w1c_clears: assert property (wr_w1c |=> w1c_value ==
      (($past(w1c_value) & ~$past(acc_wdata[EVT_HI:`EVT_LO])) | $past(w1c_set)))
      else $error("write-only one-clear field wrong after write");
   a_w1c_reads_zero: assert property (rd_w1c |=> acc_rdata == 32'h0000_0000)
      else $error("write-only field returned data");
   // write-one-set field only ever gains bits
   a_w1s_sets: assert property (wr_w1s |=> w1s_value == ($past(w1s_value) | $past(acc_wdata[EVT_HI:`EVT_LO])))
      else $error("write-one-set field wrong after write");
   a_w1s_holds: assert property (!wr_w1s |=> $stable(w1s_value))
      else $error("write-one-set field changed without write");
   a_miss_answer: assert property (acc_req && !any_hit |=> acc_ack && acc_miss && acc_rdata == 32'h0000_0000)
      else $error("unmapped access answered wrongly");

   // every taken request is answered once, one edge later, and never otherwise
   a_ack_follows: assert property (acc_req |=> acc_ack)
      else $error("request not answered");
   a_ack_only_req: assert property (!acc_req |=> !acc_ack)
      else $error("answer without a request");
   a_write_rdata_zero: assert property (acc_req && acc_we |=> acc_rdata == 32'h0000_0000)
      else $error("write returned read data");
   a_miss_no_effect: assert property (acc_req && !any_hit |=> $stable(ctrl_field) && $stable(w1s_value))
      else $error("unmapped access changed a field");

   // stored fields move only through their own access or a hardware set
   a_ctrl_holds: assert property (!wr_ctrl |=> $stable(ctrl_field))
      else $error("read-write field changed without write");
   a_wac_holds_idle: assert property (!wr_wac |=> (wac_value & $past(wac_value)) == $past(wac_value))
      else $error("write-any-clears field lost bits without a write");
   a_rw1c_read_keeps: assert property (hit_rw1c && !acc_we |=>
      rw1c_value == ($past(rw1c_value) | $past(rw1c_set)))
      else $error("status read disturbed one-clear field");

   // reset check runs with the disable lifted, so it covers the reset cycles too
   a_reset_load: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> ctrl_field == `RST_CTRL && rc_value == EVT_W'(`RST_EVT) && w1s_value == EVT_W'(`RST_W1S)
      && !acc_ack)
      else $error("field missed its reset value");

endmodule : register_bank

// file: test/register_field_access_types_bench.sv
`timescale 1ns/1ns
`include "regfield_map.svh"
module register_field_access_types_bench;
   // nonzero base so every hit proves base plus offset decoding
   localparam logic [31:0] BASE = 32'h4000_2000;
   logic clk, sys_rst, acc_req, acc_we, acc_ack, acc_miss;
   logic [31:0] acc_addr, acc_wdata, acc_rdata, hw_ro_value;
   logic [7:0] rc_set, wac_set, rw1c_set, w1c_set;
   logic [7:0] rc_value, wac_value, rw1c_value, w1c_value, w1s_value;
   logic [16:0] ctrl_field;
   int miscompares, checked;

   register_bank #(.BASE_ADDR(BASE), .EVT_W(8)) DUT (.clk(clk), .sys_rst(sys_rst), .acc_req(acc_req),
      .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack),
      .acc_miss(acc_miss), .hw_ro_value(hw_ro_value), .rc_set(rc_set), .wac_set(wac_set), .rw1c_set(rw1c_set),
      .w1c_set(w1c_set), .ctrl_field(ctrl_field), .rc_value(rc_value), .wac_value(wac_value),
      .rw1c_value(rw1c_value), .w1c_value(w1c_value), .w1s_value(w1s_value));
   sw_master sw (.clk(clk), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_miss(acc_miss),
      .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata));

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // read, checking data and the ack/miss pair together
   task automatic rd(input logic [31:0] off, input logic [31:0] exp, input logic miss_exp);
      logic [31:0] q;
      logic k, m;
      sw.access(1'b0, BASE + off, 32'h0000_0000, q, k, m);
      chk(q, exp);
      chk({30'h0, k, m}, {30'h0, 1'b1, miss_exp});
   endtask : rd

   task automatic wr(input logic [31:0] off, input logic [31:0] d);
      logic [31:0] q;
      logic k, m;
      sw.access(1'b1, BASE + off, d, q, k, m);
      chk({q[29:0], k, m}, 32'h0000_0002);
   endtask : wr

   // one-cycle hardware event burst on all four event inputs
   task automatic ev(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
      {rc_set, wac_set, rw1c_set, w1c_set} = {a, b, c, d};
      @(posedge clk);
      #1;
      {rc_set, wac_set, rw1c_set, w1c_set} = 32'h0000_0000;
   endtask : ev

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk({rc_value, wac_value, rw1c_value, w1c_value}, 32'h0000_0000);
      chk({7'h00, w1s_value, ctrl_field}, 32'h0000_0000);
      for (int i = 0; i < 7; i++)
         rd(32'(i * 4), 32'h0000_0000, 1'b0);
   endtask : t_reset

   task automatic t_ctrl;
      logic [31:0] q;
      wr(`OFF_CTRL, 32'hFFFF_FFFF);
      chk({15'h0000, ctrl_field}, 32'h0001_FFFF);
      rd(`OFF_CTRL, 32'hFFFF_8000, 1'b0);
      wr(`OFF_CTRL, 32'h0001_8000);
      rd(`OFF_CTRL, 32'h0001_8000, 1'b0);
      // back to back: the read must already see the write of the edge before
      sw.wr_rd(BASE + `OFF_CTRL, 32'h5555_8000, q);
      chk(q, 32'h5555_8000);
      chk({15'h0000, ctrl_field}, 32'h0000_AAAB);
   endtask : t_ctrl

   task automatic t_ro;
      hw_ro_value = 32'hA5C3_3C5A;
      wr(`OFF_RO, `RST_RO);
      rd(`OFF_RO, 32'hA5C3_3C5A, 1'b0);
      rd(32'h0000_001C, 32'h0000_0000, 1'b1);
   endtask : t_ro

   task automatic t_events;
      ev(8'h5A, 8'h3C, 8'h0F, 8'hFF);
      rd(`OFF_RC, 32'h0000_005A, 1'b0);
      chk({24'h0, rc_value}, 32'h0000_0000);
      rd(`OFF_RC, 32'h0000_0000, 1'b0);
      // event held across the read edge: the set must beat the clear
      rc_set = 8'h21;
      rd(`OFF_RC, 32'h0000_0021, 1'b0);
      rc_set = 8'h00;
      chk({24'h0, rc_value}, 32'h0000_0021);
      rd(`OFF_RC, 32'h0000_0021, 1'b0);
      chk({24'h0, rc_value}, 32'h0000_0000);
      rd(`OFF_WAC, 32'h0000_003C, 1'b0);
      wr(`OFF_WAC, 32'h0000_0000);
      chk({24'h0, wac_value}, 32'h0000_0000);
      rd(`OFF_RW1C, 32'h0000_000F, 1'b0);
      ev(8'h00, 8'h00, 8'hF0, 8'h00);
      wr(`OFF_RW1C, 32'h0000_000F);
      chk({24'h0, rw1c_value}, 32'h0000_00F0);
      wr(`OFF_RW1C, 32'h0000_0030);
      chk({24'h0, rw1c_value}, 32'h0000_00C0);
      wr(`OFF_W1C, 32'h0000_000F);
      chk({24'h0, w1c_value}, 32'h0000_00F0);
      rd(`OFF_W1C, 32'h0000_0000, 1'b0);
   endtask : t_events

   task automatic t_w1s;
      wr(`OFF_W1S, 32'h0000_0081);
      wr(`OFF_W1S, 32'h0000_0000);
      rd(`OFF_W1S, 32'h0000_0081, 1'b0);
   endtask : t_w1s

   // second reset in mid-run, with fields holding nonzero values
   task automatic t_rerun;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk({rc_value, wac_value, rw1c_value, w1c_value}, 32'h0000_0000);
      chk({7'h00, w1s_value, ctrl_field}, 32'h0000_0000);
      rd(`OFF_W1S, 32'h0000_0000, 1'b0);
      rd(`OFF_CTRL, 32'h0000_0000, 1'b0);
   endtask : t_rerun

   ////////////////////////////////////////////////////////////////////////////
   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // reset, then the scenarios in order
   initial begin
      sys_rst = 1'b1;
      hw_ro_value = 32'h0000_0000;
      {rc_set, wac_set, rw1c_set, w1c_set} = 32'h0000_0000;
      miscompares = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_reset();
      t_ctrl();
      t_ro();
      t_events();
      t_w1s();
      t_rerun();
      end_sim();
   end

   // watchdog: the run needs a few hundred cycles at most
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
endmodule : register_field_access_types_bench

// file: test/sw_master.sv
`timescale 1ns/1ns
// software side of the access bus, one access at a time
module sw_master (
   input wire logic clk,
   input wire logic [31:0] acc_rdata,
   input wire logic acc_ack,
   input wire logic acc_miss,
   output logic acc_req,
   output logic acc_we,
   output logic [31:0] acc_addr,
   output logic [31:0] acc_wdata
);
   // idle bus at time zero
   initial begin
      acc_req = 1'b0;
      acc_we = 1'b0;
      acc_addr = 32'h0000_0000;
      acc_wdata = 32'h0000_0000;
   end
   // one-cycle pulse: a held request would be taken as a second access
   task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic ack, output logic miss);
      @(posedge clk);
      #1;
      acc_req = 1'b1;
      acc_we = we;
      acc_addr = a;
      acc_wdata = d;
      @(posedge clk);
      #1;
      acc_req = 1'b0;
      // released lines show the inverse, never the stale word
      acc_addr = ~a;
      acc_wdata = ~d;
      q = acc_rdata;
      ack = acc_ack;
      miss = acc_miss;
   endtask : access
   // write then read back on consecutive edges, request held high between them
   task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      #1;
      acc_req = 1'b1;
      acc_we = 1'b1;
      acc_addr = a;
      acc_wdata = d;
      @(posedge clk);
      #1;
      acc_we = 1'b0;
      acc_wdata = ~d;
      @(posedge clk);
      #1;
      acc_req = 1'b0;
      acc_addr = ~a;
      q = acc_rdata;
   endtask : wr_rd
endmodule : sw_master
